// ### rtl/tsio_ports.sv
// Implementation choices: the AXI4-Lite slave port and the address map.
`default_nettype none
module tsio_ports #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Bidirectional port pins
  input wire logic [7:0] port8_pin_in,
  output logic [7:0] port8_pin_out,
  output logic [7:0] port8_pin_oe,
  // Input-only analog port pins
  input wire logic [7:0] analog_port_pin_in,
  // Timer side
  input wire tsio_pkg::tsio_tmr_out_type tmr_out,
  output logic timer_ext_clock_in,
  output logic [3:0] timer_chan_pins
);
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    tsio_pkg::tsio_tctl_type tctl;
    logic [7:0] adc_sel;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } tsio_top_state_type;

  tsio_top_state_type st_r, st_nxt;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [7:0] port8_level;
  logic [7:0] analog_level;
  logic [7:0] data_rd;
  logic [7:0] levels_rd;
  tsio_pkg::tsio_pin_drive_type drive;

  // Refuse address widths the decoder cannot serve
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 32");
  end

  // Register index of a byte address
  function automatic tsio_pkg::tsio_reg_type decode(
    input logic [ADDR_W-1:0] a
  );
    logic [31:0] wa;
    wa = 32'(a);
    case (wa)
      tsio_pkg::OFS_DIR: decode = tsio_pkg::REG_DIR;
      tsio_pkg::OFS_DATA: decode = tsio_pkg::REG_DATA;
      tsio_pkg::OFS_LEVELS: decode = tsio_pkg::REG_LEVELS;
      tsio_pkg::OFS_TCTL: decode = tsio_pkg::REG_TCTL;
      tsio_pkg::OFS_ADC: decode = tsio_pkg::REG_ADC;
      default: decode = tsio_pkg::REG_NONE;
    endcase
  endfunction : decode

  // Pin synchronisers, both ports in one bank
  tsio_pin_sync #(
    .W(16)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({analog_port_pin_in, port8_pin_in}),
    .level({analog_level, port8_level})
  );

  // Pin function selection
  tsio_pin_mux u_mux (
    .dir(st_r.dir),
    .data(st_r.data),
    .tctl(st_r.tctl),
    .tmr(tmr_out),
    .drive(drive)
  );

  // Handshakes on the bus channels
  assign aw_hs = s_axi_awvalid && st_r.awready;
  assign w_hs = s_axi_wvalid && st_r.wready;
  assign ar_hs = s_axi_arvalid && st_r.arready;

  // Read views of the two data registers
  assign data_rd = (st_r.dir & st_r.data) |
                   (~st_r.dir & port8_level);
  assign levels_rd = analog_level & ~st_r.adc_sel;

  // Bus slave and register file
  always_comb begin
    st_nxt = st_r;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_hs) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // Write lands once address and data are both held
    if (st_nxt.aw_have && st_nxt.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = tsio_pkg::RESP_OKAY;
      case (decode(st_nxt.awaddr))
        tsio_pkg::REG_DIR: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.dir = st_nxt.wdata[7:0];
          end
        end
        tsio_pkg::REG_DATA: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.data = st_nxt.wdata[7:0];
          end
        end
        tsio_pkg::REG_LEVELS: begin
          st_nxt.bresp = tsio_pkg::RESP_OKAY;
        end
        tsio_pkg::REG_TCTL: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.tctl[7:0] = st_nxt.wdata[7:0];
          end
          if (st_nxt.wstrb[1]) begin
            st_nxt.tctl[tsio_pkg::TCTL_W-1:8] =
              st_nxt.wdata[tsio_pkg::TCTL_W-1:8];
          end
        end
        tsio_pkg::REG_ADC: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.adc_sel = st_nxt.wdata[7:0];
          end
        end
        default: begin
          st_nxt.bresp = tsio_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.rresp = tsio_pkg::RESP_OKAY;
      case (decode(s_axi_araddr))
        tsio_pkg::REG_DIR: begin
          st_nxt.rdata = 32'h0000_0000;
        end
        tsio_pkg::REG_DATA: begin
          st_nxt.rdata[7:0] = data_rd;
        end
        tsio_pkg::REG_LEVELS: begin
          st_nxt.rdata[7:0] = levels_rd;
        end
        tsio_pkg::REG_TCTL: begin
          st_nxt.rdata[tsio_pkg::TCTL_W-1:0] = st_r.tctl;
        end
        tsio_pkg::REG_ADC: begin
          st_nxt.rdata[7:0] = st_r.adc_sel;
        end
        default: begin
          st_nxt.rresp = tsio_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Ready only while nothing is pending on the channel
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
    // Registered pin drive
    st_nxt.pin_out = drive.out;
    st_nxt.pin_oe = drive.oe;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.dir <= tsio_pkg::DIR_RST;
      st_r.data <= tsio_pkg::DATA_RST;
      st_r.tctl <= tsio_pkg::TCTL_RST;
      st_r.adc_sel <= tsio_pkg::ADC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign port8_pin_out = st_r.pin_out;
  assign port8_pin_oe = st_r.pin_oe;
  // Timer input paths stay connected in every mode
  assign timer_ext_clock_in = port8_level[tsio_pkg::PIN_EXT_CLK];
  assign timer_chan_pins = port8_level[4:1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Named steps of a read
  sequence s_ar_data;
    ar_hs && decode(s_axi_araddr) == tsio_pkg::REG_DATA;
  endsequence
  sequence s_ar_levels;
    ar_hs && decode(s_axi_araddr) == tsio_pkg::REG_LEVELS;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rresp == tsio_pkg::RESP_OKAY;
  endsequence

  // Plain pin direction and data
  a_gpio_dir_oe: assert property (
    port8_pin_oe[7:5] == $past(st_r.dir[7:5])
  ) else $error("general pin enable does not follow direction");
  a_gpio_out_data: assert property (
    $past(st_r.dir[7]) |-> port8_pin_out[7] == $past(st_r.data[7])
  ) else $error("general output does not carry stored data");

  // Data register reads
  a_read_stored: assert property (
    s_ar_data |=> s_rd_done and
      ((s_axi_rdata[7:0] & $past(st_r.dir)) ==
       ($past(st_r.data) & $past(st_r.dir)))
  ) else $error("output bit does not read stored data");
  a_read_pin_level: assert property (
    s_ar_data |=> s_rd_done and
      ((s_axi_rdata[7:0] & ~$past(st_r.dir)) ==
       ($past(port8_level) & ~$past(st_r.dir)))
  ) else $error("input bit does not read pin level");

  // Timer takeover of pins
  a_pin4_pwm: assert property (
    st_r.tctl.chan_d_pwm_enable |=>
      port8_pin_oe[4] && port8_pin_out[4] == $past(tmr_out.pwm[2])
  ) else $error("pin four not carrying channel D PWM");
  a_pin4_compare: assert property (
    !st_r.tctl.chan_d_pwm_enable && tsio_pkg::cmp_sel(st_r.tctl.io_d)
    |=> port8_pin_oe[4] && port8_pin_out[4] == $past(tmr_out.cmp[3])
  ) else $error("pin four not carrying channel D compare");
  a_pin4_gpio: assert property (
    !st_r.tctl.chan_d_pwm_enable && !tsio_pkg::cmp_sel(st_r.tctl.io_d)
    |=> port8_pin_oe[4] == $past(st_r.dir[4])
  ) else $error("pin four not following its direction bit");
  a_pin3_func: assert property (
    !st_r.tctl.chan_c_pwm_enable && tsio_pkg::cmp_sel(st_r.tctl.io_c)
    |=> port8_pin_oe[3] && port8_pin_out[3] == $past(tmr_out.cmp[2])
  ) else $error("pin three not carrying channel C compare");
  a_pin3_pwm: assert property (
    st_r.tctl.chan_c_pwm_enable |=>
      port8_pin_oe[3] && port8_pin_out[3] == $past(tmr_out.pwm[1])
  ) else $error("pin three not carrying channel C PWM");
  a_pin2_func: assert property (
    st_r.tctl.chan_b_pwm_enable |=>
      port8_pin_oe[2] && port8_pin_out[2] == $past(tmr_out.pwm[0])
  ) else $error("pin two not carrying channel B PWM");
  a_pin2_gpio: assert property (
    !st_r.tctl.chan_b_pwm_enable && !tsio_pkg::cmp_sel(st_r.tctl.io_b)
    |=> port8_pin_oe[2] == $past(st_r.dir[2])
  ) else $error("pin two not following its direction bit");
  a_pin1_func: assert property (
    tsio_pkg::cmp_sel(st_r.tctl.io_a) |=>
      port8_pin_oe[1] && port8_pin_out[1] == $past(tmr_out.cmp[0])
  ) else $error("pin one not carrying channel A compare");
  a_pin1_gpio: assert property (
    !tsio_pkg::cmp_sel(st_r.tctl.io_a) |=>
      port8_pin_oe[1] == $past(st_r.dir[1]) &&
      port8_pin_out[1] == $past(st_r.data[1])
  ) else $error("pin one not acting as general I/O");
  a_pin0_clock: assert property (
    port8_pin_oe[0] == $past(st_r.dir[0]) &&
    port8_pin_out[0] == $past(st_r.data[0])
  ) else $error("pin zero not following direction and data alone");

  // Analog port reads
  a_levels_read: assert property (
    s_ar_levels |=> s_rd_done and
      ((s_axi_rdata[7:0] | $past(st_r.adc_sel)) ==
       ($past(analog_level) | $past(st_r.adc_sel)))
  ) else $error("analog port read not showing pin levels");
  a_analog_zero: assert property (
    s_ar_levels |=> (s_axi_rdata[7:0] & $past(st_r.adc_sel)) == 8'h00
  ) else $error("analog channel bit not read as zero");

  // Reset state
  a_reset_clear: assert property (
    $rose(aresetn) |-> st_r.dir == tsio_pkg::DIR_RST &&
      st_r.data == tsio_pkg::DATA_RST && port8_pin_oe == 8'h00
  ) else $error("port registers not cleared by reset");

  // Bus answers hold until taken
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before bready");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data dropped before rready");
endmodule : tsio_ports
`default_nettype wire

// ### inc/tsio_pkg.sv
`default_nettype none
package tsio_pkg;
  // Port geometry and register map
  localparam int unsigned PORT_W = 8;
  localparam int unsigned TCTL_W = 15;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [31:0] OFS_DIR = 32'h0000_0000;
  localparam logic [31:0] OFS_DATA = 32'h0000_0004;
  localparam logic [31:0] OFS_LEVELS = 32'h0000_0008;
  localparam logic [31:0] OFS_TCTL = 32'h0000_000C;
  localparam logic [31:0] OFS_ADC = 32'h0000_0010;
  // Values after reset
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [14:0] TCTL_RST = 15'h0000;
  localparam logic [7:0] ADC_RST = 8'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin positions of the timer functions
  localparam int unsigned PIN_EXT_CLK = 0;
  localparam int unsigned PIN_CHAN_A = 1;

  typedef enum {
    REG_DIR, REG_DATA, REG_LEVELS, REG_TCTL, REG_ADC, REG_NONE
  } tsio_reg_type;

  // Timer pin control copy, msb first
  typedef struct packed {
    logic chan_d_pwm_enable;
    logic chan_c_pwm_enable;
    logic chan_b_pwm_enable;
    logic [2:0] io_d;
    logic [2:0] io_c;
    logic [2:0] io_b;
    logic [2:0] io_a;
  } tsio_tctl_type;

  // Timer outputs: cmp[0..3] channels A..D, pwm[0..2] B..D
  typedef struct packed {
    logic [3:0] cmp;
    logic [2:0] pwm;
  } tsio_tmr_out_type;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } tsio_pin_drive_type;

  // Compare output selected by codes 001 and 01X
  function automatic logic cmp_sel(input logic [2:0] sel);
    cmp_sel = !sel[2] && (sel != 3'h0);
  endfunction : cmp_sel
endpackage : tsio_pkg
`default_nettype wire

// ### rtl/tsio_pin_sync.sv
`default_nettype none
module tsio_pin_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pins and filtered levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } tsio_sync_state_type;

  tsio_sync_state_type st_r, st_nxt;

  // Refuse an empty bank
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  // Three stages; level moves once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s3) |
               ((st_r.s2 ^ st_r.s3) & st_r.q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.q;
endmodule : tsio_pin_sync
`default_nettype wire

// ### rtl/tsio_pin_mux.sv
`default_nettype none
module tsio_pin_mux (
  // Port registers
  input wire logic [7:0] dir,
  input wire logic [7:0] data,
  // Timer control and timer outputs
  input wire tsio_pkg::tsio_tctl_type tctl,
  input wire tsio_pkg::tsio_tmr_out_type tmr,
  // Resulting pin drive
  output tsio_pkg::tsio_pin_drive_type drive
);
  logic [3:0] pwm_en;
  logic [3:0][2:0] io_sel;
  logic [3:0] pwm_val;

  // Per-channel views, channel A has no PWM
  assign pwm_en = {tctl.chan_d_pwm_enable, tctl.chan_c_pwm_enable,
                   tctl.chan_b_pwm_enable, 1'b0};
  assign io_sel = {tctl.io_d, tctl.io_c, tctl.io_b, tctl.io_a};
  assign pwm_val = {tmr.pwm, 1'b0};

  // Timer takeover of pins one to four
  always_comb begin
    drive.out = data;
    drive.oe = dir;
    for (int i = 0; i < 4; i++) begin
      if (pwm_en[i]) begin
        drive.out[tsio_pkg::PIN_CHAN_A + i] = pwm_val[i];
        drive.oe[tsio_pkg::PIN_CHAN_A + i] = 1'b1;
      end else if (tsio_pkg::cmp_sel(io_sel[i])) begin
        drive.out[tsio_pkg::PIN_CHAN_A + i] = tmr.cmp[i];
        drive.oe[tsio_pkg::PIN_CHAN_A + i] = 1'b1;
      end
    end
  end
endmodule : tsio_pin_mux
`default_nettype wire

// ### bench/tsio_board.sv
`default_nettype none
module tsio_board (
  // Device drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Board-side sources
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pin levels
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device drive wins, then board source, else pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else begin
        pin_level[i] = ext_en[i] ? ext_val[i] : 1'b1;
      end
    end
  end
endmodule : tsio_board
`default_nettype wire

// ### bench/tsio_ports_tb.sv
`default_nettype none
module tsio_ports_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
  // Clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  // Pins and timer side
  logic [7:0] p8_out, p8_oe, p8_lvl, ana = 8'h00;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  tsio_pkg::tsio_tmr_out_type tmr = '0;
  logic ext_clk;
  logic [3:0] chan_pins;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;

  always #25 aclk = ~aclk;

  tsio_ports tsio_ports_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .port8_pin_in(p8_lvl),
    .port8_pin_out(p8_out), .port8_pin_oe(p8_oe),
    .analog_port_pin_in(ana), .tmr_out(tmr),
    .timer_ext_clock_in(ext_clk), .timer_chan_pins(chan_pins));

  tsio_board tsio_board_i (.pin_out(p8_out), .pin_oe(p8_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_level(p8_lvl));

  // Closing report
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // Bus write; address and data released as each is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] exr);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        `CHK("bresp", exr, bresp)
        break;
      end
    end
  endtask : wr

  // Bus read
  task automatic rdr(input logic [11:0] a, output logic [31:0] d,
                     input logic [1:0] exr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        `CHK("rresp", exr, rresp)
        break;
      end
    end
  endtask : rdr

  // Reset state of port registers and pins
  task automatic t_reset();
    `CHK("oe_rst", 8'h00, p8_oe)
    rdr(12'h004, rd, tsio_pkg::RESP_OKAY);
    `CHK("data_rst", 32'h0000_00FF, rd)
    $display("test reset done");
  endtask : t_reset

  // Mixed directions: stored bits out, live levels in
  task automatic t_gpio();
    ext_en <= 8'hF0;
    ext_val <= 8'h60;
    wr(12'h000, 32'h0000_000F, tsio_pkg::RESP_OKAY);
    wr(12'h004, 32'h0000_00A5, tsio_pkg::RESP_OKAY);
    idle(6);
    `CHK("oe", 8'h0F, p8_oe)
    `CHK("out", 8'h05, p8_out & 8'h0F)
    rdr(12'h004, rd, tsio_pkg::RESP_OKAY);
    `CHK("data_rd", 32'h0000_0065, rd)
    `CHK("ext_clk", 1'b1, ext_clk)
    wr(12'h004, 32'h0000_00A4, tsio_pkg::RESP_OKAY);
    idle(6);
    `CHK("ext_clk", 1'b0, ext_clk)
    $display("test gpio done");
  endtask : t_gpio

  // Compare-output codes on pins 1..4, then PWM takeover
  task automatic t_timer();
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    logic sel;
    ext_en <= 8'h00;
    tmr <= '{cmp: 4'b1010, pwm: 3'b010};
    wr(12'h000, 32'h0000_0000, tsio_pkg::RESP_OKAY);
    foreach (codes[k]) begin
      sel = (codes[k] != 3'h0) && !codes[k][2];
      wr(12'h00C, {20'h0_0000, {4{codes[k]}}}, tsio_pkg::RESP_OKAY);
      idle(6);
      `CHK("cmp_oe", sel ? 4'hF : 4'h0, p8_oe[4:1])
      `CHK("cmp_pins", sel ? 4'b1010 : 4'hF, chan_pins)
      if (sel) `CHK("cmp_out", 4'b1010, p8_out[4:1])
    end
    wr(12'h00C, 32'h0000_7249, tsio_pkg::RESP_OKAY);
    idle(2);
    `CHK("pwm_out", 4'b0100, p8_out[4:1])
    tmr <= '{cmp: 4'b1010, pwm: 3'b100};
    wr(12'h00C, 32'h0000_7000, tsio_pkg::RESP_OKAY);
    idle(2);
    `CHK("pwm_oe", 4'b1110, p8_oe[4:1])
    `CHK("pwm_d", 1'b1, p8_out[4])
    `CHK("pwm_bc", 2'b00, p8_out[3:2])
    $display("test timer done");
  endtask : t_timer

  // Reset in mid-run clears stored data and direction
  task automatic t_rerst();
    @(posedge aclk);
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    idle(6);
    `CHK("oe_rerst", 8'h00, p8_oe)
    wr(12'h000, 32'h0000_00FF, tsio_pkg::RESP_OKAY);
    rdr(12'h004, rd, tsio_pkg::RESP_OKAY);
    `CHK("data_rerst", 32'h0000_0000, rd)
    $display("test rerst done");
  endtask : t_rerst

  // Analog port levels, ignored writes, analog-selected bits
  task automatic t_analog();
    ana <= 8'hC3;
    idle(6);
    rdr(12'h008, rd, tsio_pkg::RESP_OKAY);
    `CHK("levels", 32'h0000_00C3, rd)
    wr(12'h008, 32'h0000_00FF, tsio_pkg::RESP_OKAY);
    rdr(12'h008, rd, tsio_pkg::RESP_OKAY);
    `CHK("levels_wr", 32'h0000_00C3, rd)
    wr(12'h010, 32'h0000_0081, tsio_pkg::RESP_OKAY);
    rdr(12'h008, rd, tsio_pkg::RESP_OKAY);
    `CHK("levels_adc", 32'h0000_0042, rd)
    $display("test analog done");
  endtask : t_analog

  // Unmapped address refused
  task automatic t_unmapped();
    wr(12'h040, 32'h0000_00FF, tsio_pkg::RESP_SLVERR);
    rdr(12'h040, rd, tsio_pkg::RESP_SLVERR);
    `CHK("unmapped_rd", 32'h0000_0000, rd)
    $display("test unmapped done");
  endtask : t_unmapped

  // Main sequence
  initial begin
    idle(10);
    aresetn <= 1'b1;
    idle(6);
    t_reset();
    t_gpio();
    t_rerst();
    t_timer();
    t_analog();
    t_unmapped();
    print_verdict();
  end
endmodule : tsio_ports_tb
`default_nettype wire
